/* File: shared/resp_framer_consts.vh */
// Constants for the memory card response framer
`ifndef RESP_FRAMER_CONSTS_VH
`define RESP_FRAMER_CONSTS_VH

// ----------------------------------------
// Response formats
// ----------------------------------------
`define FMT_R1          2'h0
`define FMT_R1B         2'h1
`define FMT_R2          2'h2
`define FMT_R3          2'h3
`define LEN_SHORT       8'h30
`define LEN_LONG        8'h88
`define R2_RESERVED     6'h3F
`define R3_RESERVED     6'h3F
`define R3_CRC_FILL     7'h7F

// ----------------------------------------
// Card states
// ----------------------------------------
`define ST_IDLE         4'h0
`define ST_READY        4'h1
`define ST_INACTIVE     4'hA

// ----------------------------------------
// Command indices
// ----------------------------------------
`define CMD_SEND_CID    6'h02
`define CMD_SEND_CSD    6'h09
`define CMD_GET_CID     6'h0A
`define CMD_OP_COND     6'h29
`define CMD_QUEUE_LO    6'h2B
`define CMD_QUEUE_HI    6'h2F

// ----------------------------------------
// Timing and CRC7 polynomial
// ----------------------------------------
`define NCR_MIN_CLK     8'h02
`define CRC7_POLY       7'h09

`endif

/* File: verilog/resp_framer.v */
// Response framer for the memory card command line
// Behaviour
// - ACMD41 in idle, conditions good, not busy: move to ready.
// - ACMD41 in idle, conditions good but busy: stay idle.
// - ACMD41 in idle with failed condition check: go inactive.
// - Busy while initialising, or capacity bit 0 on high-capacity card.
// - Commands 43 to 47 are illegal outside command queue mode.
// - Responses go out serially on command line, leftmost bit first.
// - Start bit 0, then direction bit 0 from the card.
// - Every response carries CRC except the R3 type; R2 sends register bits 7:1 in place of a computed CRC.
// - Last bit of every response is end bit 1.
// - R1 is 48 bits; bits 45:40 hold command index.
// - R1 bits 39:8 status, 7:1 CRC7, bit 0 end bit.
// - Card may hold data line busy after each received block.
// - R1b formatted as R1, optionally with busy on data line.
// - R2 is 136 bits, bits 133:128 all ones.
// - R2 carries identification for 2 and 10, specific data for 9.
// - R2 sends register bits 127..1; end bit replaces bit 0.
// - R3 is 48 bits, contents in 39:8, ones in 7:1.
`timescale 1ns/10ps
`include "resp_framer_consts.vh"

module resp_framer (
    input  wire         clk,
    input  wire         nrst,
    input  wire         bus_clk,
    input  wire         resp_req,
    input  wire [1:0]   resp_fmt,
    input  wire [5:0]   cmd_index,
    input  wire [31:0]  resp_arg,
    input  wire         is_app_cmd,
    input  wire         ocr_check_ok,
    input  wire         host_capacity_support_bit,
    input  wire         high_capacity,
    input  wire         init_running,
    input  wire         command_queue_mode,
    input  wire [127:0] card_identification_register,
    input  wire [127:0] card_specific_data_register,
    input  wire         busy_req,
    input  wire         busy_release,
    output reg          cmd_out,
    output reg          cmd_oe,
    output reg          dat0_out,
    output reg          dat0_oe,
    output reg          resp_busy,
    output reg          illegal_cmd,
    output reg  [3:0]   card_state,
    output reg          card_busy
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [6:0] crc7_step;
        input [6:0] crc;
        input       bit_in;
        reg         fb;
        begin
            fb = crc[6] ^ bit_in;
            crc7_step = {crc[5:0], 1'b0} ^ (fb ? `CRC7_POLY : 7'h00);
        end
    endfunction

    function lead_bit;
        input [135:0] word;
        input [1:0]   fmt;
        begin
            if (fmt == `FMT_R2) begin
                lead_bit = word[135];
            end else begin
                lead_bit = word[47];
            end
        end
    endfunction

    function queue_index;
        input [5:0] idx;
        begin
            queue_index = (idx >= `CMD_QUEUE_LO) &&
                          (idx <= `CMD_QUEUE_HI);
        end
    endfunction

    function [7:0] frame_len;
        input [1:0] fmt;
        begin
            if (fmt == `FMT_R2) begin
                frame_len = `LEN_LONG;
            end else begin
                frame_len = `LEN_SHORT;
            end
        end
    endfunction

    // ----------------------------------------
    // Bus clock synchroniser and edge finder
    // ----------------------------------------
    // Sampling the bus clock keeps one domain; bus clock must be slow
    reg        bclk_s1_reg;
    reg        bclk_s2_reg;
    reg        bclk_s3_reg;
    wire       bclk_fall;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bclk_s1_reg <= 1'b0;
            bclk_s2_reg <= 1'b0;
            bclk_s3_reg <= 1'b0;
        end else begin
            bclk_s1_reg <= bus_clk;
            bclk_s2_reg <= bclk_s1_reg;
            bclk_s3_reg <= bclk_s2_reg;
        end
    end

    // Bits change on falling edge so host samples on rising
    assign bclk_fall = bclk_s3_reg & ~bclk_s2_reg;

    // ----------------------------------------
    // Codeword assembly
    // ----------------------------------------
    reg [135:0] word_next;
    reg [7:0]   len_next;
    reg [5:0]   idx_field;
    reg [127:0] reg_image;

    always @* begin
        idx_field = cmd_index;
        reg_image = card_specific_data_register;
        word_next = 136'h0;
        len_next  = frame_len(resp_fmt);
        case (resp_fmt)
            `FMT_R2: begin
                if (cmd_index == `CMD_SEND_CID ||
                    cmd_index == `CMD_GET_CID) begin
                    reg_image = card_identification_register;
                end else begin
                    reg_image = card_specific_data_register;
                end
                word_next = {2'b00, `R2_RESERVED,
                             reg_image[127:1], 1'b1};
            end
            `FMT_R3: begin
                word_next = {88'h0, 2'b00, `R3_RESERVED, resp_arg,
                             `R3_CRC_FILL, 1'b1};
            end
            default: begin
                word_next = {88'h0, 2'b00, idx_field, resp_arg,
                             7'h00, 1'b1};
            end
        endcase
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    localparam TX_IDLE = 2'h0;
    localparam TX_WAIT = 2'h1;
    localparam TX_SEND = 2'h2;
    localparam TX_CRC  = 2'h3;

    reg [1:0]   tx_state_reg;
    reg [135:0] shift_reg;
    reg [7:0]   bits_left_reg;
    reg [7:0]   wait_cnt_reg;
    reg [6:0]   crc_reg;
    reg [2:0]   crc_cnt_reg;
    reg [1:0]   fmt_reg;
    reg         skip_crc;

    always @* begin
        skip_crc = (fmt_reg == `FMT_R3) || (fmt_reg == `FMT_R2);
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_state_reg  <= TX_IDLE;
            shift_reg     <= 136'h0;
            bits_left_reg <= 8'h00;
            wait_cnt_reg  <= 8'h00;
            crc_reg       <= 7'h00;
            crc_cnt_reg   <= 3'h0;
            fmt_reg       <= `FMT_R1;
            cmd_out       <= 1'b1;
            cmd_oe        <= 1'b0;
            resp_busy     <= 1'b0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    cmd_oe  <= 1'b0;
                    cmd_out <= 1'b1;
                    if (resp_req) begin
                        shift_reg     <= word_next;
                        bits_left_reg <= len_next;
                        fmt_reg       <= resp_fmt;
                        wait_cnt_reg  <= `NCR_MIN_CLK;
                        crc_reg       <= 7'h00;
                        resp_busy     <= 1'b1;
                        tx_state_reg  <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (bclk_fall) begin
                        if (wait_cnt_reg == 8'h00) begin
                            tx_state_reg <= TX_SEND;
                        end else begin
                            wait_cnt_reg <= wait_cnt_reg - 8'h01;
                        end
                    end
                end
                TX_SEND: begin
                    if (bclk_fall) begin
                        if (bits_left_reg == 8'h00) begin
                            cmd_oe       <= 1'b0;
                            cmd_out      <= 1'b1;
                            resp_busy    <= 1'b0;
                            tx_state_reg <= TX_IDLE;
                        end else if (!skip_crc && bits_left_reg == 8'h08) begin
                            crc_cnt_reg  <= 3'h6;
                            cmd_out      <= crc_reg[6];
                            crc_reg      <= {crc_reg[5:0], 1'b0};
                            tx_state_reg <= TX_CRC;
                        end else begin
                            cmd_oe  <= 1'b1;
                            // Leftmost bit first; start/dir bits are 0
                            cmd_out <= lead_bit(shift_reg,
                                                fmt_reg);
                            // CRC over every bit before the CRC field
                            crc_reg <= crc7_step(crc_reg,
                                       lead_bit(shift_reg, fmt_reg));
                            shift_reg     <= {shift_reg[134:0], 1'b0};
                            bits_left_reg <= bits_left_reg - 8'h01;
                        end
                    end
                end
                TX_CRC: begin
                    if (bclk_fall) begin
                        if (crc_cnt_reg == 3'h0) begin
                            cmd_out       <= 1'b1;
                            bits_left_reg <= 8'h00;
                            tx_state_reg  <= TX_SEND;
                        end else begin
                            cmd_out     <= crc_reg[6];
                            crc_reg     <= {crc_reg[5:0], 1'b0};
                            crc_cnt_reg <= crc_cnt_reg - 3'h1;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Request acceptance
    // ----------------------------------------
    // Requests during a frame are dropped without notice
    reg req_take;

    always @* begin
        req_take = resp_req && (tx_state_reg == TX_IDLE);
    end

    // ----------------------------------------
    // Data line busy
    // ----------------------------------------
    // Busy holds until released; host must poll data line
    reg busy_armed_reg;
    reg busy_armed_next;

    always @* begin
        busy_armed_next = busy_armed_reg;
        if (busy_req && !resp_req) begin
            busy_armed_next = 1'b1;
        end else if (req_take && resp_fmt == `FMT_R1B && busy_req) begin
            busy_armed_next = 1'b1;
        end else if (busy_release) begin
            busy_armed_next = 1'b0;
        end
    end

    // Runs on clk: host may stop the bus clock while busy
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_armed_reg <= 1'b0;
            dat0_oe        <= 1'b0;
            dat0_out       <= 1'b1;
        end else begin
            busy_armed_reg <= busy_armed_next;
            dat0_oe        <= busy_armed_reg;
            dat0_out       <= ~busy_armed_reg;
        end
    end

    // ----------------------------------------
    // Card state for initialisation
    // ----------------------------------------
    reg       busy_now;
    reg       op_cond_cmd;
    reg [3:0] card_state_next;
    reg       card_busy_next;
    reg       illegal_next;

    always @* begin
        busy_now = init_running |
                   (high_capacity & ~host_capacity_support_bit);
        op_cond_cmd = req_take & is_app_cmd &
                      (cmd_index == `CMD_OP_COND);
        card_state_next = card_state;
        card_busy_next  = card_busy;
        illegal_next    = illegal_cmd;
        if (op_cond_cmd && card_state == `ST_IDLE) begin
            card_busy_next = busy_now;
            if (!ocr_check_ok) begin
                card_state_next = `ST_INACTIVE;
            end else if (busy_now) begin
                card_state_next = `ST_IDLE;
            end else begin
                card_state_next = `ST_READY;
            end
        end
        if (req_take) begin
            illegal_next = !is_app_cmd && !command_queue_mode &&
                           queue_index(cmd_index);
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            card_state  <= `ST_IDLE;
            card_busy   <= 1'b0;
            illegal_cmd <= 1'b0;
        end else begin
            card_state  <= card_state_next;
            card_busy   <= card_busy_next;
            illegal_cmd <= illegal_next;
        end
    end

endmodule

/* File: bench/resp_framer_assertions.sv */
// Port assertions for the response framer
`timescale 1ns/10ps
`include "resp_framer_consts.vh"
module resp_framer_assertions (
    input logic       clk,
    input logic       nrst,
    input logic       resp_req,
    input logic [5:0] cmd_index,
    input logic       is_app_cmd,
    input logic       ocr_check_ok,
    input logic       host_capacity_support_bit,
    input logic       high_capacity,
    input logic       init_running,
    input logic       command_queue_mode,
    input logic       busy_release,
    input logic       cmd_out,
    input logic       cmd_oe,
    input logic       dat0_out,
    input logic       dat0_oe,
    input logic       resp_busy,
    input logic       illegal_cmd,
    input logic [3:0] card_state,
    input logic       card_busy
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
wire take = resp_req && !resp_busy;
wire op41 = take && is_app_cmd && cmd_index == `CMD_OP_COND
    && card_state == `ST_IDLE;
wire hold = init_running || (!host_capacity_support_bit && high_capacity);
// ----------------------------------------
// Properties
// ----------------------------------------
sequence s_lead; (cmd_oe && !cmd_out) [*8]; endsequence
sequence s_slot; (!cmd_oe) [*8]; endsequence
property p_lead; $rose(cmd_oe) |-> s_lead; endproperty
property p_end; $fell(cmd_oe) |-> $past(cmd_out); endproperty
property p_slot; $rose(resp_busy) |-> s_slot; endproperty
property p_idle; !cmd_oe |-> cmd_out; endproperty
property p_take; take |=> resp_busy; endproperty
property p_ill; take && !is_app_cmd && !command_queue_mode
    && cmd_index >= `CMD_QUEUE_LO && cmd_index <= `CMD_QUEUE_HI
    |=> illegal_cmd; endproperty
property p_fail; op41 && !ocr_check_ok |=> card_state == `ST_INACTIVE;
endproperty
property p_ready; op41 && ocr_check_ok && !hold |=> card_state == `ST_READY;
endproperty
property p_stay; op41 && ocr_check_ok && hold
    |=> card_state == `ST_IDLE && card_busy; endproperty
property p_dat; dat0_oe |-> !dat0_out; endproperty
property p_rel; busy_release |-> ##[1:4] !dat0_oe; endproperty
a_lead: assert property (p_lead) else $error("lead bits");
a_end: assert property (p_end) else $error("end bit");
a_slot: assert property (p_slot) else $error("early start");
a_idle: assert property (p_idle) else $error("idle level");
a_take: assert property (p_take) else $error("not taken");
a_ill: assert property (p_ill) else $error("illegal flag");
a_fail: assert property (p_fail) else $error("not inactive");
a_ready: assert property (p_ready) else $error("not ready");
a_stay: assert property (p_stay) else $error("not held");
a_dat: assert property (p_dat) else $error("busy level");
a_rel: assert property (p_rel) else $error("busy stuck");
endmodule

/* File: bench/host_model.sv */
// Host controller model: bus clock and response capture
`timescale 1ns/10ps
module host_model (
    input  logic         run,
    input  logic         cmd_out,
    input  logic         cmd_oe,
    input  logic         dat0_out,
    input  logic         dat0_oe,
    output logic         bus_clk,
    output logic [135:0] cap,
    output int           ncap,
    output logic         busy_seen
);
// Clock stands still between frames; offset keeps it off clk edges
initial begin
    bus_clk = 1'b0;
    forever if (run) #80 bus_clk = ~bus_clk; else begin @(run); #3; end
end
// Pull-up keeps the released command line high
wire cmd_line = cmd_oe ? cmd_out : 1'b1;
initial cap = '0;
always @(posedge run) ncap = 0;
always @(posedge bus_clk) begin
    if (cmd_oe) begin
        cap = {cap[134:0], cmd_line};
        ncap = ncap + 1;
    end
    busy_seen = dat0_oe && !dat0_out;
end
endmodule

/* File: bench/resp_framer_tb.sv */
// Self-checking bench for the response framer
`timescale 1ns/10ps
`include "resp_framer_consts.vh"
module resp_framer_tb;
logic         clk, nrst, bus_clk, resp_req, is_app_cmd, ocr_check_ok;
logic         host_capacity_support_bit, high_capacity, init_running;
logic         command_queue_mode, busy_req, busy_release, run;
logic [1:0]   resp_fmt;
logic [5:0]   cmd_index;
logic [31:0]  resp_arg;
logic [127:0] card_identification_register, card_specific_data_register;
logic         cmd_out, cmd_oe, dat0_out, dat0_oe, resp_busy, illegal_cmd;
logic         card_busy, busy_seen;
logic [3:0]   card_state;
logic [135:0] cap;
int           ncap, error_cnt, n_compared, cycles;
resp_framer DUT (.*);
host_model partner (.run, .cmd_out, .cmd_oe, .dat0_out, .dat0_oe,
    .bus_clk, .cap, .ncap, .busy_seen);
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
// Hang guard: suite needs well under this many cycles
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
        error_cnt++;
        end_sim();
    end
end
task end_sim;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task automatic check(input [135:0] got, input [135:0] exp);
    n_compared++;
    if (got !== exp) begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
function automatic [6:0] crc7(input [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int k = 39; k >= 0; k--)
        c = {c[5:0], 1'b0} ^ ((d[k] ^ c[6]) ? `CRC7_POLY : 7'h00);
    return c;
endfunction
task automatic do_reset;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
endtask
// One full response; frame judged against the expected codeword
task automatic resp(input [1:0] f, input [5:0] i, input [31:0] a, input b);
    logic [127:0] r;
    logic [135:0] e;
    resp_fmt <= f;
    cmd_index <= i;
    resp_arg <= a;
    busy_req <= b;
    resp_req <= 1'b1;
    @(posedge clk);
    resp_req <= 1'b0;
    busy_req <= 1'b0;
    run <= 1'b1;
    repeat (3) @(posedge clk);
    for (int n = 0; n < 30000 && resp_busy; n++) @(posedge clk);
    run <= 1'b0;
    @(posedge clk);
    r = (i == `CMD_SEND_CSD) ? card_specific_data_register
        : card_identification_register;
    if (f == `FMT_R2)
        e = {2'b00, `R2_RESERVED, r[127:1], 1'b1};
    else if (f == `FMT_R3)
        e = {88'h0, 2'b00, `R3_RESERVED, a, `R3_CRC_FILL, 1'b1};
    else
        e = {88'h0, 2'b00, i, a, crc7({2'b00, i, a}), 1'b1};
    check(f == `FMT_R2 ? cap : {88'h0, cap[47:0]}, e);
    check(ncap, f == `FMT_R2 ? 136 : 48);
endtask
task automatic t_r2;
    resp(`FMT_R2, `CMD_SEND_CID, 32'h0, 1'b0);
    resp(`FMT_R2, `CMD_SEND_CSD, 32'h0, 1'b0);
    resp(`FMT_R2, `CMD_GET_CID, 32'h0, 1'b0);
endtask
task automatic t_op41;
    logic [3:0] cfg [4] = '{4'hB, 4'hE, 4'h9, 4'h2};
    logic [3:0] st [4] = '{`ST_READY, `ST_IDLE, `ST_IDLE, `ST_INACTIVE};
    is_app_cmd <= 1'b1;
    for (int k = 0; k < 4; k++) begin
        do_reset();
        {ocr_check_ok, init_running, host_capacity_support_bit,
            high_capacity} <= cfg[k];
        resp(`FMT_R3, `CMD_OP_COND, 32'hC0FF_8000, 1'b0);
        check(card_state, st[k]);
        check(card_busy, k == 1 || k == 2);
    end
    is_app_cmd <= 1'b0;
endtask
task automatic t_illegal;
    for (int q = 0; q < 2; q++) begin
        command_queue_mode <= q[0];
        for (int k = 42; k < 49; k++) begin
            resp(`FMT_R1, k[5:0], 32'h8000_0001, 1'b0);
            check(illegal_cmd, q == 0 && k > 42 && k < 48);
        end
    end
endtask
task automatic t_busy;
    resp(`FMT_R1B, 6'h3F, 32'h0000_0900, 1'b1);
    check({dat0_oe, dat0_out, busy_seen}, 3'h5);
    busy_release <= 1'b1;
    @(posedge clk);
    busy_release <= 1'b0;
    repeat (4) @(posedge clk);
    check(dat0_oe, 1'b0);
    busy_req <= 1'b1;
    @(posedge clk);
    busy_req <= 1'b0;
    repeat (4) @(posedge clk);
    check({dat0_oe, dat0_out}, 2'h2);
    busy_release <= 1'b1;
    @(posedge clk);
    busy_release <= 1'b0;
    repeat (4) @(posedge clk);
    check(dat0_oe, 1'b0);
endtask
initial begin
    {nrst, resp_req, is_app_cmd, ocr_check_ok, init_running, run} = '0;
    {host_capacity_support_bit, high_capacity, command_queue_mode} = '0;
    {busy_req, busy_release, resp_fmt, cmd_index, resp_arg} = '0;
    card_identification_register = {4{32'h89AB_CDEF}};
    card_specific_data_register = {4{32'h0123_4566}};
    {error_cnt, n_compared, cycles} = '0;
    do_reset();
    t_r2();
    t_busy();
    t_illegal();
    t_op41();
    end_sim();
end
endmodule
bind resp_framer resp_framer_assertions chk (.*);
